// File: core/ibsm_pkg.sv
package ibsm_pkg;

  // ************************************************************
  // Block geometry
  // ************************************************************
  localparam int MAX_ACC = 6;
  localparam int OCT_W = 8;
  localparam int SIG_W = 2;
  localparam int BRR_W = MAX_ACC * 2 * OCT_W;
  localparam int SIGS_W = MAX_ACC * SIG_W;
  localparam int BLK_W = BRR_W + SIGS_W + 1;
  localparam int FIFO_DEPTH = 16;
  localparam logic [2:0] EOC_MAX_ACC = 3'h4;
  localparam logic [2:0] FSC_MAX_ACC = 3'h6;
  localparam logic [2:0] Z_MAX = 3'h7;
  localparam logic [5:0] OCT_MIN = 6'h03;
  localparam logic [5:0] OCT_MAX = 6'h24;
  localparam logic [3:0] OCT_LAST_BIT = 4'h8;
  localparam logic [3:0] FSC_Z_POS = 4'h1;
  localparam logic [5:0] SIG_OCT_SLOT = 6'h01;

  typedef struct packed {
    logic [5:0] b1;
    logic d_oct;
    logic [3:0] d_pos;
  } ibsm_map_t;

  typedef struct packed {
    logic in_z;
    logic [3:0] z;
    logic [5:0] slot;
    logic [3:0] bitn;
  } ibsm_pos_t;

  // ************************************************************
  // Slot allocation
  // ************************************************************
  // Slot of the first bearer octet and first signalling bit of access k (1-based).
  function automatic ibsm_map_t map_acc(input logic fsc, input logic [2:0] cnt,
                                        input logic [2:0] k);
    ibsm_map_t m;
    logic [5:0] k6;
    logic [5:0] lz;
    k6 = {3'h0, k};
    lz = 6'h00;
    m.d_oct = 1'b0;
    if (cnt <= 3'h3)
    begin
      m.b1 = 6'(2 * k6 - 6'h01);
      m.d_pos = 4'(2 * k6 - 6'h01 + {5'h00, fsc});
    end
    else
    begin
      if (fsc)
      begin
        lz = {3'h0, 3'(cnt - EOC_MAX_ACC)};
      end
      m.b1 = 6'(2 * k6);
      if (k6 <= lz)
      begin
        m.d_pos = 4'(2 * k6);
      end
      else
      begin
        m.d_oct = 1'b1;
        m.d_pos = 4'(2 * (k6 - lz) - 6'h01);
      end
    end
    return m;
  endfunction : map_acc

  function automatic logic cfg_valid(input logic fsc, input logic [2:0] cnt,
                                     input logic [2:0] zc, input logic [5:0] nc);
    logic [2:0] mi;
    logic [5:0] mn;
    if (cnt <= 3'h3)
    begin
      mi = 3'(2 * cnt + {2'h0, fsc});
      mn = 6'(2 * {3'h0, cnt});
    end
    else
    begin
      mi = fsc ? 3'(2 * (cnt - EOC_MAX_ACC) + 3'h1) : 3'h0;
      mn = 6'(2 * {3'h0, cnt} + 6'h01);
    end
    return (cnt != 3'h0) && (cnt <= FSC_MAX_ACC) && (fsc || cnt <= EOC_MAX_ACC) &&
           (zc <= Z_MAX) && (zc >= mi) && (nc >= OCT_MIN) && (nc <= OCT_MAX) && (nc >= mn);
  endfunction : cfg_valid

  function automatic ibsm_pos_t pos_start(input logic [2:0] zc);
    ibsm_pos_t p;
    p.in_z = (zc != 3'h0);
    p.z = 4'h1;
    p.slot = 6'h01;
    p.bitn = 4'h1;
    return p;
  endfunction : pos_start

  function automatic ibsm_pos_t pos_next(input ibsm_pos_t p, input logic [2:0] zc);
    ibsm_pos_t q;
    q = p;
    if (p.in_z)
    begin
      if (p.z == {1'b0, zc})
      begin
        q.in_z = 1'b0;
        q.slot = 6'h01;
        q.bitn = 4'h1;
      end
      else
      begin
        q.z = 4'(p.z + 4'h1);
      end
    end
    else if (p.bitn == OCT_LAST_BIT)
    begin
      q.slot = 6'(p.slot + 6'h01);
      q.bitn = 4'h1;
    end
    else
    begin
      q.bitn = 4'(p.bitn + 4'h1);
    end
    return q;
  endfunction : pos_next

  function automatic logic pos_last(input ibsm_pos_t p, input logic [5:0] nc);
    return !p.in_z && (p.slot == nc) && (p.bitn == OCT_LAST_BIT);
  endfunction : pos_last

endpackage : ibsm_pkg

// File: core/ibsm_link_if.sv
`timescale 1ns/1ps
interface ibsm_link_if;
  logic lk_bit;
  logic lk_vld;
  logic lk_sob;

  modport mapper (output lk_bit, output lk_vld, output lk_sob);
  modport extractor (input lk_bit, input lk_vld, input lk_sob);
endinterface : ibsm_link_if

// File: core/ibsm_mapper.sv
// Contract
// R1: Signalling bits go one block after bearers.
// R2: Last-block signalling moves to next frame's first.
// R3: Without fast channel, at most four accesses.
// R4: Eoc, 1-3 accesses: octets 2k-1,2k; Z 2k-1,2k.
// R5: Eoc, four accesses: octets 2k,2k+1; octet1 bit pairs.
// R6: Fast channel rides in single-bit slot 1.
// R7: Fast channel allows up to six accesses.
// R8: Fast, 1-3 accesses: octets 2k-1,2k; Z 2k,2k+1.
// R9: Fast, four accesses: octets 2k,2k+1; octet1 pairs.
// R10: Fast, five: access1 Z2,Z3; rest octet1 pairs.
// R11: Fast, six: accesses 1,2 on Z; rest octet1.
// R12: Message codes travel in HDLC-like eoc messages.
// R13: Either end may originate eoc messages.
// R14: Messages default to the embedded operations channel.
// R15: More than four accesses requires fast channel.
// R16: Fast channel optional for latency or congestion.
// R17: Block is i single bits then n octets.
// R18: Lifeline access owns the first slots.
// R19: Octet1 bit 1 first; pair order kept.
`timescale 1ns/1ps

// ************************************************************
// Block buffer
// ************************************************************
module ibsm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk, // Clock.
  input wire logic rst, // Synchronous reset.
  input wire logic wr_vld, // Write request.
  output logic wr_rdy, // Space available.
  input wire logic [WIDTH-1:0] wr_data, // Write word.
  output logic rd_vld, // Word available.
  input wire logic rd_rdy, // Read accept.
  output logic [WIDTH-1:0] rd_data // Head word.
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic do_wr;
  logic do_rd;

  assign do_wr = wr_vld && wr_rdy;
  assign do_rd = rd_vld && rd_rdy;
  assign rd_data = mem[rp_ff];

  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (do_wr && !do_rd)
    begin
      nxt_cnt = CW'(cnt_ff + 1'b1);
    end
    else if (do_rd && !do_wr)
    begin
      nxt_cnt = CW'(cnt_ff - 1'b1);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (do_wr)
    begin
      mem[wp_ff] <= wr_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
      wr_rdy <= 1'b0;
      rd_vld <= 1'b0;
    end
    else
    begin
      if (do_wr)
      begin
        wp_ff <= (wp_ff == AW'(DEPTH - 1)) ? '0 : AW'(wp_ff + 1'b1);
      end
      if (do_rd)
      begin
        rp_ff <= (rp_ff == AW'(DEPTH - 1)) ? '0 : AW'(rp_ff + 1'b1);
      end
      cnt_ff <= nxt_cnt;
      wr_rdy <= (nxt_cnt != CW'(DEPTH));
      rd_vld <= (nxt_cnt != '0);
    end
  end
endmodule : ibsm_fifo

// ************************************************************
// Mapper end
// ************************************************************
module ibsm_mapper (
  input wire logic mclk, // Clock, 125 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic cfg_fsc, // Fast signalling channel enabled.
  input wire logic [2:0] cfg_acc_cnt, // Number of accesses, 1..6.
  input wire logic [2:0] cfg_z_cnt, // Single-bit slots per block.
  input wire logic [5:0] cfg_oct_cnt, // Octet slots per block.
  input wire logic in_vld, // Block of access data offered.
  output logic in_rdy, // Buffer can take a block.
  input wire logic [ibsm_pkg::BRR_W-1:0] in_bearer, // Two octets per access.
  input wire logic [ibsm_pkg::SIGS_W-1:0] in_sig, // Two signalling bits per access.
  input wire logic in_fast, // Fast signalling channel bit.
  output logic cfg_err, // Configuration not allowed.
  ibsm_link_if.mapper lnk // Payload bit stream.
);
  typedef enum logic {IBSM_IDLE, IBSM_SEND} ibsm_st_t;

  logic fifo_vld;
  logic fifo_pop;
  logic [ibsm_pkg::BLK_W-1:0] fifo_word;
  logic cfg_ok;
  logic last;
  logic nxt_bit;
  ibsm_st_t st_ff;
  ibsm_pkg::ibsm_pos_t pos_ff;
  logic [ibsm_pkg::BRR_W-1:0] brr_ff;
  logic [ibsm_pkg::SIGS_W-1:0] sig_hold_ff;
  logic [ibsm_pkg::SIGS_W-1:0] sig_send_ff;
  logic fast_ff;
  logic sob_ff;

  ibsm_fifo #(
    .WIDTH(ibsm_pkg::BLK_W),
    .DEPTH(ibsm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .wr_vld(in_vld),
    .wr_rdy(in_rdy),
    .wr_data({in_bearer, in_sig, in_fast}),
    .rd_vld(fifo_vld),
    .rd_rdy(fifo_pop),
    .rd_data(fifo_word)
  );

  assign cfg_ok = ibsm_pkg::cfg_valid(cfg_fsc, cfg_acc_cnt, cfg_z_cnt, cfg_oct_cnt); // R3 R7 R15 R17
  assign last = ibsm_pkg::pos_last(pos_ff, cfg_oct_cnt);
  // Blocks follow back to back, so a frame edge needs no special case.
  assign fifo_pop = fifo_vld && cfg_ok && (st_ff == IBSM_IDLE || last); // R2

  // ************************************************************
  // Slot multiplexer
  // ************************************************************
  always_comb
  begin
    ibsm_pkg::ibsm_map_t m;
    m = '0;
    nxt_bit = 1'b0;
    if (pos_ff.in_z)
    begin
      if (cfg_fsc && pos_ff.z == ibsm_pkg::FSC_Z_POS)
      begin
        nxt_bit = fast_ff; // R6 R12 R14 R16
      end
    end
    for (int k = 0; k < ibsm_pkg::MAX_ACC; k++)
    begin
      m = ibsm_pkg::map_acc(cfg_fsc, cfg_acc_cnt, 3'(k + 1)); // R4 R5 R8 R9 R10 R11 R18
      if (3'(k) < cfg_acc_cnt)
      begin
        if (pos_ff.in_z)
        begin
          if (!m.d_oct && pos_ff.z == m.d_pos)
          begin
            nxt_bit = sig_send_ff[2 * k + 1]; // R1
          end
          if (!m.d_oct && pos_ff.z == 4'(m.d_pos + 4'h1))
          begin
            nxt_bit = sig_send_ff[2 * k];
          end
        end
        else
        begin
          if (pos_ff.slot == m.b1)
          begin
            nxt_bit = brr_ff[16 * k + 32'(pos_ff.bitn) - 1];
          end
          if (pos_ff.slot == 6'(m.b1 + 6'h01))
          begin
            nxt_bit = brr_ff[16 * k + 8 + 32'(pos_ff.bitn) - 1];
          end
          if (m.d_oct && pos_ff.slot == ibsm_pkg::SIG_OCT_SLOT)
          begin
            if (pos_ff.bitn == m.d_pos)
            begin
              nxt_bit = sig_send_ff[2 * k + 1]; // R19
            end
            if (pos_ff.bitn == 4'(m.d_pos + 4'h1))
            begin
              nxt_bit = sig_send_ff[2 * k];
            end
          end
        end
      end
    end
  end

  // ************************************************************
  // Block sequencing
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_ff <= IBSM_IDLE;
      pos_ff <= '0;
      sob_ff <= 1'b0;
    end
    else if (fifo_pop)
    begin
      st_ff <= IBSM_SEND;
      pos_ff <= ibsm_pkg::pos_start(cfg_z_cnt); // R17
      sob_ff <= 1'b1;
    end
    else if (st_ff == IBSM_SEND)
    begin
      sob_ff <= 1'b0;
      if (last)
      begin
        st_ff <= IBSM_IDLE;
      end
      else
      begin
        pos_ff <= ibsm_pkg::pos_next(pos_ff, cfg_z_cnt);
      end
    end
  end

  // The signalling of a block is parked and sent with the following block.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      brr_ff <= '0;
      sig_hold_ff <= '0;
      sig_send_ff <= '0;
      fast_ff <= 1'b0;
    end
    else if (fifo_pop)
    begin
      brr_ff <= fifo_word[ibsm_pkg::BLK_W-1 -: ibsm_pkg::BRR_W];
      sig_send_ff <= sig_hold_ff; // R1
      sig_hold_ff <= fifo_word[ibsm_pkg::SIGS_W:1];
      fast_ff <= fifo_word[0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lnk.lk_bit <= 1'b0;
      lnk.lk_vld <= 1'b0;
      lnk.lk_sob <= 1'b0;
      cfg_err <= 1'b0;
    end
    else
    begin
      lnk.lk_bit <= (st_ff == IBSM_SEND) ? nxt_bit : 1'b0;
      lnk.lk_vld <= (st_ff == IBSM_SEND);
      lnk.lk_sob <= sob_ff;
      cfg_err <= !cfg_ok;
    end
  end
endmodule : ibsm_mapper

// File: core/ibsm_extractor.sv
`timescale 1ns/1ps

// ************************************************************
// Extractor end
// ************************************************************
module ibsm_extractor (
  input wire logic mclk, // Clock, 125 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic cfg_fsc, // Fast signalling channel enabled.
  input wire logic [2:0] cfg_acc_cnt, // Number of accesses, 1..6.
  input wire logic [2:0] cfg_z_cnt, // Single-bit slots per block.
  input wire logic [5:0] cfg_oct_cnt, // Octet slots per block.
  ibsm_link_if.extractor lnk, // Payload bit stream.
  output logic out_vld, // One-cycle pulse: block of access data.
  output logic [ibsm_pkg::BRR_W-1:0] out_bearer, // Two octets per access.
  output logic [ibsm_pkg::SIGS_W-1:0] out_sig, // Signalling matching out_bearer.
  output logic out_fast // Fast channel bit of the latest block.
);
  ibsm_pkg::ibsm_pos_t cur;
  ibsm_pkg::ibsm_pos_t pos_ff;
  logic [ibsm_pkg::BRR_W-1:0] brr_ff;
  logic [ibsm_pkg::BRR_W-1:0] prev_brr_ff;
  logic [ibsm_pkg::SIGS_W-1:0] sig_ff;
  logic fast_ff;
  logic prev_ok_ff;
  logic [ibsm_pkg::BRR_W-1:0] nxt_brr;
  logic [ibsm_pkg::SIGS_W-1:0] nxt_sig;
  logic nxt_fast;

  assign cur = lnk.lk_sob ? ibsm_pkg::pos_start(cfg_z_cnt) : pos_ff;

  // ************************************************************
  // Slot demultiplexer
  // ************************************************************
  always_comb
  begin
    ibsm_pkg::ibsm_map_t m;
    m = '0;
    nxt_brr = brr_ff;
    nxt_sig = sig_ff;
    nxt_fast = fast_ff;
    if (cur.in_z && cfg_fsc && cur.z == ibsm_pkg::FSC_Z_POS)
    begin
      nxt_fast = lnk.lk_bit; // R6 R13
    end
    for (int k = 0; k < ibsm_pkg::MAX_ACC; k++)
    begin
      m = ibsm_pkg::map_acc(cfg_fsc, cfg_acc_cnt, 3'(k + 1));
      if (3'(k) < cfg_acc_cnt)
      begin
        if (cur.in_z)
        begin
          if (!m.d_oct && cur.z == m.d_pos)
          begin
            nxt_sig[2 * k + 1] = lnk.lk_bit;
          end
          if (!m.d_oct && cur.z == 4'(m.d_pos + 4'h1))
          begin
            nxt_sig[2 * k] = lnk.lk_bit;
          end
        end
        else
        begin
          if (cur.slot == m.b1)
          begin
            nxt_brr[16 * k + 32'(cur.bitn) - 1] = lnk.lk_bit;
          end
          if (cur.slot == 6'(m.b1 + 6'h01))
          begin
            nxt_brr[16 * k + 8 + 32'(cur.bitn) - 1] = lnk.lk_bit;
          end
          if (m.d_oct && cur.slot == ibsm_pkg::SIG_OCT_SLOT && cur.bitn == m.d_pos)
          begin
            nxt_sig[2 * k + 1] = lnk.lk_bit;
          end
          if (m.d_oct && cur.slot == ibsm_pkg::SIG_OCT_SLOT &&
              cur.bitn == 4'(m.d_pos + 4'h1))
          begin
            nxt_sig[2 * k] = lnk.lk_bit;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pos_ff <= '0;
      brr_ff <= '0;
      sig_ff <= '0;
      fast_ff <= 1'b0;
    end
    else if (lnk.lk_vld)
    begin
      pos_ff <= ibsm_pkg::pos_next(cur, cfg_z_cnt);
      brr_ff <= nxt_brr;
      sig_ff <= nxt_sig;
      fast_ff <= nxt_fast;
    end
  end

  // Signalling of block N+1 is rejoined with the bearers of block N; the
  // first block after reset has no partner and is not reported.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prev_brr_ff <= '0;
      prev_ok_ff <= 1'b0;
      out_vld <= 1'b0;
      out_bearer <= '0;
      out_sig <= '0;
      out_fast <= 1'b0;
    end
    else
    begin
      out_vld <= 1'b0;
      if (lnk.lk_vld && ibsm_pkg::pos_last(cur, cfg_oct_cnt))
      begin
        prev_brr_ff <= nxt_brr;
        prev_ok_ff <= 1'b1;
        out_vld <= prev_ok_ff;
        out_bearer <= prev_brr_ff;
        out_sig <= nxt_sig;
        out_fast <= nxt_fast;
      end
    end
  end
endmodule : ibsm_extractor

// File: dv/ibsm_link_sva.sv
`timescale 1ns/1ps
module ibsm_link_sva (
  input wire logic mclk, // Clock.
  input wire logic rst, // Synchronous reset.
  input wire logic lk_bit, // Link bit.
  input wire logic lk_vld, // Link bit valid.
  input wire logic lk_sob, // Block start.
  input wire logic cfg_fsc, // Fast channel on.
  input wire logic [2:0] cfg_acc_cnt, // Accesses.
  input wire logic [2:0] cfg_z_cnt, // Single-bit slots.
  input wire logic [5:0] cfg_oct_cnt, // Octet slots.
  input wire logic cfg_err, // Illegal config.
  input wire logic out_vld, // Extracted block.
  input wire logic out_fast // Extracted fast bit.
);
  logic [8:0] pos_ff;
  logic [8:0] blk_len;
  logic [8:0] cur_pos;
  logic seen_ff;
  logic fast_ff;

  assign blk_len = {6'h00, cfg_z_cnt} + {cfg_oct_cnt, 3'h0};
  assign cur_pos = lk_sob ? 9'h000 : pos_ff;

  // ************************************************************
  // Position tracking
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (rst || (lk_vld && cur_pos == blk_len - 9'h001))
      pos_ff <= 9'h000;
    else if (lk_vld)
      pos_ff <= cur_pos + 9'h001;
  end

  // The first block after reset carries no earlier bearers, so it yields nothing.
  always_ff @(posedge mclk)
  begin
    if (rst)
      seen_ff <= 1'b0;
    else if (lk_vld && cur_pos == blk_len - 9'h001)
      seen_ff <= 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (lk_sob)
      fast_ff <= lk_bit;
  end

  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_sob_with_valid: assert property (lk_sob |-> lk_vld)
    else $error("block start without valid bit");
  a_block_no_gap: assert property (pos_ff != 9'h000 |-> lk_vld)
    else $error("gap inside a block");
  a_sob_on_boundary: assert property (lk_sob |-> pos_ff == 9'h000)
    else $error("block cut short");
  a_bit_inside_block: assert property (lk_vld |-> lk_sob || pos_ff != 9'h000)
    else $error("bit outside any block");
  a_out_after_last: assert property (lk_vld && cur_pos == blk_len - 9'h001 && seen_ff
    |=> out_vld)
    else $error("no extracted block after block end");
  a_out_only_after: assert property (out_vld |->
    $past(lk_vld) && $past(cur_pos) == blk_len - 9'h001)
    else $error("extracted block at wrong time");
  a_fast_bit_z1: assert property (out_vld && cfg_fsc |-> out_fast == fast_ff)
    else $error("fast bit not from first single-bit slot");
  a_idle_on_err: assert property (cfg_err |-> !lk_vld)
    else $error("blocks sent with illegal config");
  a_eoc4_z_zero: assert property (lk_vld && !cfg_fsc && cfg_acc_cnt == 3'h4 &&
    cur_pos < {6'h00, cfg_z_cnt} |-> !lk_bit)
    else $error("unused single-bit slot not zero");

  c_fast_out: cover property (out_vld && cfg_fsc);
  c_back_to_back: cover property (lk_vld && cur_pos == blk_len - 9'h001 ##1 lk_sob);
  c_cfg_err: cover property (cfg_err);
endmodule : ibsm_link_sva

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int NB = 16;
  logic mclk, rst, cfg_fsc, in_vld, in_rdy, in_fast, cfg_err, out_vld, out_fast;
  logic [2:0] cfg_acc_cnt, cfg_z_cnt;
  logic [5:0] cfg_oct_cnt;
  logic [95:0] in_bearer, out_bearer, bmask, wb [0:31];
  logic [11:0] in_sig, out_sig, smask, ws [0:31];
  logic wf [0:31];
  logic [294:0] got_blk;
  logic [12:0] cfgs [0:13] = '{13'h0283, 13'h0504, 13'h0786, 13'h0889, 13'h12C3,
    13'h1544, 13'h17C6, 13'h1849, 13'h1ACB, 13'h1D4D, 13'h05E4, 13'h0BE4, 13'h1FE4,
    13'h0282};
  int seed = 83, bad_count = 0, n_checks = 0, nw, nblk, nout, bi;

  ibsm_link_if lnk_if ();
  ibsm_mapper ibsm_mapper_inst (.mclk(mclk), .rst(rst), .cfg_fsc(cfg_fsc),
    .cfg_acc_cnt(cfg_acc_cnt), .cfg_z_cnt(cfg_z_cnt), .cfg_oct_cnt(cfg_oct_cnt),
    .in_vld(in_vld), .in_rdy(in_rdy), .in_bearer(in_bearer), .in_sig(in_sig),
    .in_fast(in_fast), .cfg_err(cfg_err), .lnk(lnk_if));
  ibsm_extractor ibsm_extractor_inst (.mclk(mclk), .rst(rst), .cfg_fsc(cfg_fsc),
    .cfg_acc_cnt(cfg_acc_cnt), .cfg_z_cnt(cfg_z_cnt), .cfg_oct_cnt(cfg_oct_cnt),
    .lnk(lnk_if), .out_vld(out_vld), .out_bearer(out_bearer), .out_sig(out_sig),
    .out_fast(out_fast));
  ibsm_link_sva ibsm_link_sva_inst (.mclk(mclk), .rst(rst), .lk_bit(lnk_if.lk_bit),
    .lk_vld(lnk_if.lk_vld), .lk_sob(lnk_if.lk_sob), .cfg_fsc(cfg_fsc),
    .cfg_acc_cnt(cfg_acc_cnt), .cfg_z_cnt(cfg_z_cnt), .cfg_oct_cnt(cfg_oct_cnt),
    .cfg_err(cfg_err), .out_vld(out_vld), .out_fast(out_fast));

  // Unused accesses are left out of the output comparison.
  assign bmask = (96'h1 << (16 * cfg_acc_cnt)) - 96'h1;
  assign smask = (12'h001 << (2 * cfg_acc_cnt)) - 12'h001;

  // ************************************************************
  // Checks and expectations
  // ************************************************************
  task automatic cmp_vec(input logic [294:0] g, input logic [294:0] e);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp_vec

  task automatic cmp_cnt(input int g, input int e);
    n_checks++;
    if (g != e)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp_cnt

  task automatic final_report();
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  // Bearers come from word n, signalling from word n-1, fast bit from word n.
  function automatic logic [294:0] exp_blk(input int n);
    logic [294:0] e;
    logic [95:0] b;
    logic [11:0] s;
    int z, k, b1, p, lz;
    e = 295'h0;
    z = int'(cfg_z_cnt);
    b = wb[n];
    s = (n > 0) ? ws[n-1] : 12'h000;
    lz = (cfg_fsc && cfg_acc_cnt > 3'h4) ? int'(cfg_acc_cnt) - 4 : 0;
    if (cfg_fsc)
      e[0] = wf[n];
    for (k = 1; k <= int'(cfg_acc_cnt); k++)
    begin
      b1 = (cfg_acc_cnt <= 3'h3) ? 2 * k - 1 : 2 * k;
      for (int j = 0; j < 16; j++)
        e[z + 8 * (b1 - 1) + j] = b[16 * (k - 1) + j];
      if (cfg_acc_cnt <= 3'h3)
        p = 2 * k - 2 + int'(cfg_fsc);
      else if (k <= lz)
        p = 2 * k - 1;
      else
        p = z + 2 * (k - lz) - 2;
      e[p] = s[2 * k - 1];
      e[p + 1] = s[2 * k - 2];
    end
    return e;
  endfunction : exp_blk

  // ************************************************************
  // Monitors
  // ************************************************************
  always @(posedge mclk)
  begin
    if (rst)
    begin
      nblk = 0;
      nout = 0;
      bi = 0;
      got_blk = 295'h0;
    end
    else
    begin
      if (lnk_if.lk_vld)
      begin
        if (lnk_if.lk_sob)
          bi = 0;
        got_blk[bi] = lnk_if.lk_bit;
        bi++;
        if (bi == cfg_z_cnt + 8 * cfg_oct_cnt)
        begin
          cmp_vec(got_blk, exp_blk(nblk));
          nblk++;
          got_blk = 295'h0;
        end
      end
      if (out_vld)
      begin
        cmp_vec(out_bearer & bmask, wb[nout] & bmask);
        cmp_vec(out_sig & smask, ws[nout] & smask);
        if (cfg_fsc)
          cmp_vec(out_fast, wf[nout + 1]);
        nout++;
      end
    end
  end

  // ************************************************************
  // Stimulus
  // ************************************************************
  // With an illegal config nothing drains, so the buffer fills and must refuse.
  task automatic run_cfg(input logic bad);
    int cyc;
    nw = 0;
    cyc = 0;
    while (cyc < 8000 && (bad ? cyc < 200 : nout < NB - 1))
    begin
      @(posedge mclk);
      cyc++;
      if (in_vld && in_rdy)
      begin
        wb[nw] = in_bearer;
        ws[nw] = in_sig;
        wf[nw] = in_fast;
        nw++;
      end
      if (!in_vld || in_rdy)
      begin
        in_vld <= (nw < (bad ? 20 : NB)) && ($random(seed) % 4 != 0);
        in_bearer <= (nw == 1) ? ~96'h0 : {$random(seed), $random(seed), $random(seed)};
        in_sig <= (nw == 1) ? 12'hFFF : 12'($random(seed));
        in_fast <= 1'($random(seed));
      end
    end
    cmp_cnt(nw, bad ? ibsm_pkg::FIFO_DEPTH : NB);
    cmp_cnt(nblk, bad ? 0 : NB);
    cmp_cnt(nout, bad ? 0 : NB - 1);
    cmp_vec(cfg_err, bad);
  endtask : run_cfg

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial
  begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    final_report();
  end

  initial
  begin
    rst = 1'b1;
    {cfg_fsc, cfg_acc_cnt, cfg_z_cnt, cfg_oct_cnt} = cfgs[0];
    in_vld = 1'b0;
    in_bearer = 96'h0;
    in_sig = 12'h000;
    in_fast = 1'b0;
    for (int t = 0; t < 14; t++)
    begin
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      run_cfg(t >= 11);
      @(posedge mclk);
      // Config only changes while reset is held, so both ends switch together.
      rst <= 1'b1;
      in_vld <= 1'b0;
      {cfg_fsc, cfg_acc_cnt, cfg_z_cnt, cfg_oct_cnt} <= cfgs[(t + 1) % 14];
    end
    final_report();
  end
endmodule : tb
